//--- hw/oram_chan.sv
// one window evaluator: consecutive-count filter and hysteresis release
// assumes one sample strobe per completed result of its channel
`timescale 1ns/10ps
module oram_chan
  import oram_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // check carrier
  oram_chk_if.eval chk
);
  logic signed [14:0] hi_rel;
  logic signed [14:0] lo_rel;
  logic hi_out;
  logic lo_out;
  logic [2:0] hi_cnt_reg;
  logic [2:0] lo_cnt_reg;
  logic hi_alarm_reg;
  logic lo_alarm_reg;
  logic [3:0] n_eff;

  // a count of zero behaves as one conversion
  assign n_eff = (chk.count_n == 3'h0) ? 4'h1 : {1'b0, chk.count_n};
  assign hi_out = chk.value > chk.upper;
  assign lo_out = chk.value < chk.lower;
  assign hi_rel = 15'(chk.upper) - 15'(chk.hysteresis_margin);
  assign lo_rel = 15'(chk.lower) + 15'(chk.hysteresis_margin);
  assign chk.hi_alarm = hi_alarm_reg;
  assign chk.lo_alarm = lo_alarm_reg;

  // ----------------------------------------
  // upper bound
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hi_alarm_reg <= 1'b0;
      hi_cnt_reg <= 3'h0;
    end else if (chk.sample) begin
      if (hi_alarm_reg) begin
        if (15'(chk.value) <= hi_rel) begin
          hi_alarm_reg <= 1'b0;
        end
        hi_cnt_reg <= 3'h0;
      end else if (hi_out) begin
        if (({1'b0, hi_cnt_reg} + 4'h1) >= n_eff) begin
          hi_alarm_reg <= 1'b1;
          hi_cnt_reg <= 3'h0;
        end else begin
          hi_cnt_reg <= hi_cnt_reg + 3'h1;
        end
      end else begin
        hi_cnt_reg <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // lower bound
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lo_alarm_reg <= 1'b0;
      lo_cnt_reg <= 3'h0;
    end else if (chk.sample) begin
      if (lo_alarm_reg) begin
        if (15'(chk.value) >= lo_rel) begin
          lo_alarm_reg <= 1'b0;
        end
        lo_cnt_reg <= 3'h0;
      end else if (lo_out) begin
        if (({1'b0, lo_cnt_reg} + 4'h1) >= n_eff) begin
          lo_alarm_reg <= 1'b1;
          lo_cnt_reg <= 3'h0;
        end else begin
          lo_cnt_reg <= lo_cnt_reg + 3'h1;
        end
      end else begin
        lo_cnt_reg <= 3'h0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_alarm_needs_out: assert property ($rose(hi_alarm_reg) |-> $past(chk.sample && hi_out))
    else $error("upper alarm rose without an out-of-range sample");
  a_hysteresis_margin_holds: assert property (hi_alarm_reg && chk.sample && (15'(chk.value) > hi_rel)
    |=> hi_alarm_reg)
    else $error("upper alarm released inside the hysteresis band");
  a_n1_immediate: assert property (chk.sample && lo_out && !lo_alarm_reg && (n_eff == 4'h1)
    |=> lo_alarm_reg)
    else $error("lower alarm not raised with a count of one");
endmodule

//--- hw/oram_top.sv
// out-of-range alarm monitor with fault pin, converter clear and pins
// assumes one result per res_valid pulse and a simple register port
//
// What this block does
// - an out-of-window result raises an alarm and the global fault flag
// - with hold enabled, status bits stay set until their register is read
// - with hold disabled, status bits follow the live condition
// - the external fault alarm is never held and tracks its input
// - unmasked alarms drive the fault pin; masked ones only set status
// - each unipolar input has its own status bit for its window
// - temperature upper and lower limits raise high and low flags
// - enabled temperature above the fixed trip sets overheat, fixed hysteresis
// - shared pin set as external fault input is active low
// - active external fault forces selected converter outputs to zero code
// - outputs reload from active registers when the fault input goes high
// - a set alarm clears only a hysteresis margin back inside the window
// - hysteresis up to 127 codes unipolar, 31 degrees temperature
// - alarm needs N consecutive out-of-range conversions
// - temperature channel disabled after reset until enabled
// - temperature kept as 12-bit two's complement, quarter degree steps
// - temperature converted each sequence, continuous or on demand
// - output pins drive their data bit; lower four have alternate roles
// - a pin with data bit one reads back the pin level
// - pin data resets to all ones, pins released high
// - internally cleared outputs reload once no clearing alarm remains
`timescale 1ns/10ps
`include "oram_defs.svh"
module oram_top
  import oram_pkg::*;
#(
  parameter int NUM_UNI = 5,
  parameter int NUM_CONV = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // conversion results
  input wire logic res_valid,
  input wire logic [2:0] res_chan,
  input wire logic [11:0] res_data,
  input wire logic res_ready_n,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // general-purpose pins
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  // converter control
  output logic [NUM_CONV-1:0] conv_clear,
  output logic temp_conv_en,
  output logic auto_mode,
  output logic ref_buf_en,
  output logic ext_trigger
);
  localparam int NCHK = NUM_UNI + 2;
  localparam int TEMP = NUM_UNI;
  localparam int HEAT = NUM_UNI + 1;

  logic [7:0] conv_cfg_reg;
  logic [7:0] false_cfg_reg;
  logic [7:0] pin_cfg_reg;
  logic [7:0] mux2_reg;
  logic [15:0] clr_en_reg;
  logic [7:0] clr_src0_reg;
  logic [7:0] clr_src1_reg;
  logic [7:0] out_src0_reg;
  logic [7:0] out_src1_reg;
  logic [7:0] pin_data_reg;
  logic [7:0] thr_reg [0:23];
  logic [7:0] hysteresis_margin_reg [0:5];
  logic [11:0] temp_data_reg;
  logic [8:0] st_reg;
  logic [8:0] st_next;
  logic [NCHK-1:0] samp_d_reg;
  logic [7:0] rdata_reg;
  logic [7:0] gpio_out_reg;
  logic [7:0] gpio_oe_reg;
  logic [NUM_CONV-1:0] conv_clear_reg;
  logic ext_trigger_reg;
  logic [8:0] cond;
  logic [8:0] set_ev;
  logic [8:0] rd_clr;
  logic [8:0] out_mask;
  logic [8:0] clr_src;
  logic fault_active;
  logic clear_any;
  logic hold_dis;
  logic temp_en;
  logic ext_level;
  logic wr_thr;
  logic wr_hys;
  logic [7:0] rd_mux;
  logic [NCHK-1:0] samp_vec;
  logic [NCHK-1:0] hi_vec;
  logic [NCHK-1:0] lo_vec;

  assign hold_dis = out_src1_reg[`ORAM_SRC1_HOLD_DIS];
  assign temp_en = mux2_reg[`ORAM_MUX2_TEMP_EN];
  assign ext_level = pin_cfg_reg[`ORAM_PIN_EXT_FAULT] && !gpio_in[0];
  assign wr_thr = reg_wr_en && reg_addr >= `ORAM_ADDR_THR_BASE && reg_addr <= `ORAM_ADDR_THR_LAST;
  assign wr_hys = reg_wr_en && reg_addr >= `ORAM_ADDR_HYS_BASE && reg_addr <= `ORAM_ADDR_HYS_LAST;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_cfg_reg <= 8'h00;
      false_cfg_reg <= `ORAM_RST_FALSE_CFG;
      pin_cfg_reg <= 8'h00;
      mux2_reg <= 8'h00;
      clr_en_reg <= 16'h0000;
      clr_src0_reg <= 8'h00;
      clr_src1_reg <= 8'h00;
      out_src0_reg <= 8'h00;
      out_src1_reg <= 8'h00;
      pin_data_reg <= `ORAM_RST_PIN_DATA;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `ORAM_ADDR_CONV_CFG: conv_cfg_reg <= reg_wdata;
        `ORAM_ADDR_FALSE_CFG: false_cfg_reg <= reg_wdata;
        `ORAM_ADDR_PIN_CFG: pin_cfg_reg <= reg_wdata;
        `ORAM_ADDR_MUX_CFG2: mux2_reg <= reg_wdata;
        `ORAM_ADDR_CLR_EN0: clr_en_reg[7:0] <= reg_wdata;
        `ORAM_ADDR_CLR_EN1: clr_en_reg[15:8] <= reg_wdata;
        `ORAM_ADDR_CLR_SRC0: clr_src0_reg <= reg_wdata;
        `ORAM_ADDR_CLR_SRC1: clr_src1_reg <= reg_wdata;
        `ORAM_ADDR_OUT_SRC0: out_src0_reg <= reg_wdata;
        `ORAM_ADDR_OUT_SRC1: out_src1_reg <= reg_wdata;
        `ORAM_ADDR_PIN_DATA: pin_data_reg <= reg_wdata;
        default: pin_data_reg <= pin_data_reg;
      endcase
    end
  end

  // ----------------------------------------
  // thresholds and hysteresis
  // ----------------------------------------
  // byte order per channel: upper low, upper high, lower low, lower high
  function automatic logic [7:0] thr_rst(input int idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx % 4)
      0: v = `ORAM_RST_UP_LO;
      1: v = (idx / 4 == TEMP) ? `ORAM_RST_UP_HI_TEMP : `ORAM_RST_UP_HI_UNI;
      3: v = (idx / 4 == TEMP) ? `ORAM_RST_LO_HI_TEMP : 8'h00;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 24; i++) begin
        thr_reg[i] <= thr_rst(i);
      end
    end else if (wr_thr) begin
      thr_reg[5'(reg_addr - `ORAM_ADDR_THR_BASE)] <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 6; i++) begin
        hysteresis_margin_reg[i] <= `ORAM_RST_HYSTERESIS_MARGIN;
      end
    end else if (wr_hys) begin
      hysteresis_margin_reg[3'(reg_addr - `ORAM_ADDR_HYS_BASE)] <= reg_wdata;
    end
  end

  // ----------------------------------------
  // threshold evaluators
  // ----------------------------------------
  oram_chk_if chk [0:NCHK-1] ();

  genvar g;
  generate
    for (g = 0; g < NUM_UNI + 1; g++) begin : g_win
      if (g == TEMP) begin : g_temp
        // temperature is signed; hysteresis in whole degrees
        assign chk[g].sample = res_valid && res_chan == ORAM_CH_TEMP && temp_en;
        assign chk[g].value = oram_val_t'(signed'(res_data));
        assign chk[g].upper = oram_val_t'(signed'({thr_reg[4*g+1][3:0], thr_reg[4*g]}));
        assign chk[g].lower = oram_val_t'(signed'({thr_reg[4*g+3][3:0], thr_reg[4*g+2]}));
        assign chk[g].hysteresis_margin = {7'h00, hysteresis_margin_reg[g][4:0], 2'b00};
      end else begin : g_uni
        assign chk[g].sample = res_valid && res_chan == 3'(g);
        assign chk[g].value = {2'b00, res_data};
        assign chk[g].upper = {2'b00, thr_reg[4*g+1][3:0], thr_reg[4*g]};
        assign chk[g].lower = {2'b00, thr_reg[4*g+3][3:0], thr_reg[4*g+2]};
        assign chk[g].hysteresis_margin = {7'h00, hysteresis_margin_reg[g][6:0]};
      end
      assign chk[g].count_n = false_cfg_reg[2:0];
      assign samp_vec[g] = chk[g].sample;
      assign hi_vec[g] = chk[g].hi_alarm;
      assign lo_vec[g] = chk[g].lo_alarm;
      oram_chan u_chan (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .chk(chk[g])
      );
    end
  endgenerate

  // fixed overheat trip; no count filter and no programmable band
  assign chk[HEAT].sample = chk[TEMP].sample;
  assign chk[HEAT].value = chk[TEMP].value;
  assign chk[HEAT].upper = oram_val_t'(`ORAM_OVERHEAT_DEGC * `ORAM_CODES_PER_DEGC);
  assign chk[HEAT].lower = 14'h2000;
  assign chk[HEAT].hysteresis_margin = oram_val_t'(`ORAM_OVERHEAT_HYSTERESIS_MARGIN_DEGC * `ORAM_CODES_PER_DEGC);
  assign chk[HEAT].count_n = 3'h1;
  oram_chan u_heat (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .chk(chk[HEAT])
  );
  assign samp_vec[HEAT] = chk[HEAT].sample;
  assign hi_vec[HEAT] = chk[HEAT].hi_alarm;
  assign lo_vec[HEAT] = chk[HEAT].lo_alarm;

  // ----------------------------------------
  // alarm status
  // ----------------------------------------
  // bit map: 4..0 unipolar, 5 temp high, 6 temp low, 7 overheat, 8 external
  always_comb begin
    for (int i = 0; i < NUM_UNI; i++) begin
      cond[i] = hi_vec[i] || lo_vec[i];
    end
    cond[5] = chk[TEMP].hi_alarm && temp_en;
    cond[6] = chk[TEMP].lo_alarm && temp_en;
    cond[7] = chk[HEAT].hi_alarm && temp_en;
    cond[8] = ext_level;
    set_ev = {1'b0, {3{samp_d_reg[TEMP]}}, samp_d_reg[NUM_UNI-1:0]} & cond;
    rd_clr[4:0] = {5{reg_rd_en && reg_addr == `ORAM_ADDR_STAT0}};
    rd_clr[7:5] = {3{reg_rd_en && reg_addr == `ORAM_ADDR_STAT1}};
    rd_clr[8] = 1'b0;
    if (hold_dis) begin
      st_next[7:0] = cond[7:0];
    end else begin
      // set wins over a read in the same cycle
      st_next[7:0] = set_ev[7:0] | (st_reg[7:0] & ~rd_clr[7:0]);
    end
    st_next[8] = cond[8];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= 9'h000;
      samp_d_reg <= '0;
    end else begin
      st_reg <= st_next;
      samp_d_reg <= samp_vec;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      temp_data_reg <= 12'h000;
    end else if (chk[TEMP].sample) begin
      temp_data_reg <= res_data;
    end
  end

  // ----------------------------------------
  // fault pin, converter clear, pins
  // ----------------------------------------
  assign out_mask = {out_src1_reg[`ORAM_SRC1_EXT], out_src0_reg};
  assign clr_src = {clr_src1_reg[`ORAM_SRC1_EXT], clr_src0_reg};
  assign fault_active = |(st_reg & ~out_mask);
  assign clear_any = |(st_reg & clr_src);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_clear_reg <= '0;
    end else begin
      // outputs reload on their own once no clearing source stays set
      conv_clear_reg <= clr_en_reg[NUM_CONV-1:0] & {NUM_CONV{clear_any}};
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_out_reg <= 8'h00;
      gpio_oe_reg <= 8'h00;
      ext_trigger_reg <= 1'b0;
    end else begin
      // pins only pull low; a one releases to the pull-up
      gpio_out_reg <= 8'h00;
      gpio_oe_reg <= ~pin_data_reg;
      if (pin_cfg_reg[`ORAM_PIN_EXT_FAULT]) begin
        gpio_oe_reg[0] <= 1'b0;
      end
      if (pin_cfg_reg[`ORAM_PIN_FAULT_OUT]) begin
        gpio_oe_reg[1] <= fault_active;
      end
      if (pin_cfg_reg[`ORAM_PIN_TRIGGER]) begin
        gpio_oe_reg[2] <= 1'b0;
      end
      if (pin_cfg_reg[`ORAM_PIN_READY]) begin
        gpio_oe_reg[3] <= !res_ready_n;
      end
      ext_trigger_reg <= pin_cfg_reg[`ORAM_PIN_TRIGGER] && !gpio_in[2];
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr >= `ORAM_ADDR_THR_BASE && reg_addr <= `ORAM_ADDR_THR_LAST) begin
      rd_mux = thr_reg[5'(reg_addr - `ORAM_ADDR_THR_BASE)];
    end else if (reg_addr >= `ORAM_ADDR_HYS_BASE && reg_addr <= `ORAM_ADDR_HYS_LAST) begin
      rd_mux = hysteresis_margin_reg[3'(reg_addr - `ORAM_ADDR_HYS_BASE)];
    end else begin
      case (reg_addr)
        `ORAM_ADDR_CONV_CFG: rd_mux = conv_cfg_reg;
        `ORAM_ADDR_FALSE_CFG: rd_mux = false_cfg_reg;
        `ORAM_ADDR_PIN_CFG: rd_mux = pin_cfg_reg;
        `ORAM_ADDR_MUX_CFG2: rd_mux = mux2_reg;
        `ORAM_ADDR_CLR_EN0: rd_mux = clr_en_reg[7:0];
        `ORAM_ADDR_CLR_EN1: rd_mux = clr_en_reg[15:8];
        `ORAM_ADDR_CLR_SRC0: rd_mux = clr_src0_reg;
        `ORAM_ADDR_CLR_SRC1: rd_mux = clr_src1_reg;
        `ORAM_ADDR_OUT_SRC0: rd_mux = out_src0_reg;
        `ORAM_ADDR_OUT_SRC1: rd_mux = out_src1_reg;
        `ORAM_ADDR_STAT0: rd_mux = {3'h0, st_reg[4:0]};
        `ORAM_ADDR_STAT1: rd_mux = {4'h0, st_reg[8:5]};
        `ORAM_ADDR_GSTAT: rd_mux = {7'h00, |st_reg};
        `ORAM_ADDR_TEMP_LO: rd_mux = temp_data_reg[7:0];
        `ORAM_ADDR_TEMP_HI: rd_mux = {{4{temp_data_reg[11]}}, temp_data_reg[11:8]};
        `ORAM_ADDR_PIN_DATA: rd_mux = gpio_in;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata = rdata_reg;
  assign gpio_out = gpio_out_reg;
  assign gpio_oe = gpio_oe_reg;
  assign conv_clear = conv_clear_reg;
  assign temp_conv_en = mux2_reg[`ORAM_MUX2_TEMP_EN];
  assign auto_mode = conv_cfg_reg[`ORAM_CONV_AUTO];
  assign ref_buf_en = conv_cfg_reg[`ORAM_CONV_REFBUF];
  assign ext_trigger = ext_trigger_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_global_flag: assert property (reg_rd_en && reg_addr == `ORAM_ADDR_GSTAT
    |=> reg_rdata[0] == $past(|st_reg))
    else $error("global fault flag does not match status");
  a_hold_until_read: assert property (!hold_dis && st_reg[0]
    && !(reg_rd_en && reg_addr == `ORAM_ADDR_STAT0) |=> st_reg[0])
    else $error("held alarm dropped without a read");
  a_live_follow: assert property (hold_dis |=> st_reg[7:0] == $past(cond[7:0]))
    else $error("live status does not follow condition");
  a_ext_tracks: assert property (1'b1 |=> st_reg[8] == $past(ext_level))
    else $error("external fault status not tracking the pin");
  a_fault_pin: assert property (pin_cfg_reg[`ORAM_PIN_FAULT_OUT]
    |=> gpio_oe_reg[1] == $past(|(st_reg & ~out_mask)) && !gpio_out_reg[1])
    else $error("fault pin does not reflect unmasked alarms");
  a_ext_clears: assert property (st_reg[8] && clr_src1_reg[`ORAM_SRC1_EXT]
    && clr_en_reg[0] |=> conv_clear_reg[0])
    else $error("selected output not cleared by external fault");
  a_clear_release: assert property (!clear_any |=> conv_clear_reg == '0)
    else $error("output stays cleared with no clearing alarm");
  a_temp_off: assert property (!temp_en |=> $stable(temp_data_reg))
    else $error("temperature evaluated while disabled");
  a_pin_read: assert property (reg_rd_en && reg_addr == `ORAM_ADDR_PIN_DATA
    |=> reg_rdata == $past(gpio_in))
    else $error("pin data read does not return pin level");
  a_pin_drive: assert property (!pin_data_reg[7] |=> gpio_oe_reg[7] && !gpio_out_reg[7])
    else $error("plain pin not driven low for a zero data bit");

  c_held_alarm: cover property (!hold_dis && $rose(st_reg[0]));
  c_read_clear: cover property (st_reg[5] ##1 !st_reg[5] && !hold_dis);
  c_ext_clear: cover property ($rose(conv_clear_reg[0]) ##[1:20] $fell(conv_clear_reg[0]));
endmodule

//--- inc/oram_chk_if.sv
// carrier between the monitor and one threshold evaluator
// assumes values already widened to signed form by the monitor
`timescale 1ns/10ps
interface oram_chk_if;
  import oram_pkg::*;
  logic sample;
  oram_val_t value;
  oram_val_t upper;
  oram_val_t lower;
  oram_val_t hysteresis_margin;
  logic [2:0] count_n;
  logic hi_alarm;
  logic lo_alarm;
  modport eval(input sample, value, upper, lower, hysteresis_margin, count_n, output hi_alarm, lo_alarm);
  modport ctl(output sample, value, upper, lower, hysteresis_margin, count_n, input hi_alarm, lo_alarm);
endinterface

//--- inc/oram_defs.svh
// register offsets, field positions, reset values and fixed trip figures
// assumes 8-bit register offsets as seen on the device register port
`ifndef ORAM_DEFS_SVH
`define ORAM_DEFS_SVH

`define ORAM_ADDR_CONV_CFG 8'h10
`define ORAM_ADDR_FALSE_CFG 8'h11
`define ORAM_ADDR_PIN_CFG 8'h12
`define ORAM_ADDR_MUX_CFG2 8'h15
`define ORAM_ADDR_CLR_EN0 8'h18
`define ORAM_ADDR_CLR_EN1 8'h19
`define ORAM_ADDR_CLR_SRC0 8'h1A
`define ORAM_ADDR_CLR_SRC1 8'h1B
`define ORAM_ADDR_OUT_SRC0 8'h1C
`define ORAM_ADDR_OUT_SRC1 8'h1D
`define ORAM_ADDR_STAT0 8'h70
`define ORAM_ADDR_STAT1 8'h71
`define ORAM_ADDR_GSTAT 8'h72
`define ORAM_ADDR_TEMP_LO 8'h78
`define ORAM_ADDR_TEMP_HI 8'h79
`define ORAM_ADDR_PIN_DATA 8'h7A
`define ORAM_ADDR_THR_BASE 8'h80
`define ORAM_ADDR_THR_LAST 8'h97
`define ORAM_ADDR_HYS_BASE 8'hA0
`define ORAM_ADDR_HYS_LAST 8'hA5

`define ORAM_RST_FALSE_CFG 8'h07
`define ORAM_RST_PIN_DATA 8'hFF
`define ORAM_RST_HYSTERESIS_MARGIN 8'h08
`define ORAM_RST_UP_LO 8'hFF
`define ORAM_RST_UP_HI_UNI 8'h0F
`define ORAM_RST_UP_HI_TEMP 8'h07
`define ORAM_RST_LO_HI_TEMP 8'h08

`define ORAM_CONV_AUTO 0
`define ORAM_CONV_REFBUF 1
`define ORAM_PIN_EXT_FAULT 0
`define ORAM_PIN_FAULT_OUT 1
`define ORAM_PIN_TRIGGER 2
`define ORAM_PIN_READY 3
`define ORAM_MUX2_TEMP_EN 0
`define ORAM_SRC1_EXT 0
`define ORAM_SRC1_HOLD_DIS 7
`define ORAM_GSTAT_GLOBAL 0

`define ORAM_CODES_PER_DEGC 4
`define ORAM_OVERHEAT_DEGC 150
`define ORAM_OVERHEAT_HYSTERESIS_MARGIN_DEGC 8

`endif

//--- inc/oram_pkg.sv
// types shared by the alarm monitor and its channel evaluator
// assumes results of up to 12 bits, widened to signed 14 bits
package oram_pkg;
  typedef logic signed [13:0] oram_val_t;
  typedef enum logic [2:0] {
    ORAM_CH_UNI0 = 3'b000,
    ORAM_CH_UNI4 = 3'b100,
    ORAM_CH_TEMP = 3'b101
  } oram_chan_e;
endpackage

//--- verification/oram_host.sv
// host model: register port master and pin wires with pull-ups
// assumes the read answer lands on the edge that takes the strobe
`timescale 1ns/10ps
module oram_host (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic [7:0] gpio_oe,
  output logic [7:0] gpio_in
);
  // ----------------------------------------
  // pins and bus cycles
  // ----------------------------------------
  logic ext_high = 1'b1;
  logic trig_high = 1'b1;
  // pull-up wins unless the device, the fault source or the trigger source pulls low
  assign gpio_in = ~gpio_oe & {5'h1F, trig_high, 1'b1, ext_high};
  // idle bus shows inverted values so a stale address cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
  task automatic setup();
    wr(8'h10, 8'h02);
    wr(8'h12, 8'h03);
  endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for the out-of-range alarm monitor
// assumes the host model drives the register port and resolves pins
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic res_valid = 1'b0;
  logic [2:0] res_chan = 3'h0;
  logic [11:0] res_data = 12'h000;
  logic reg_wr_en, reg_rd_en, temp_conv_en, ref_buf_en, auto_mode, ext_trigger;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, gpio_in, gpio_oe, d, gpio_out;
  logic [11:0] conv_clear;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // chan, result, expected input status after the result
  logic [22:0] rows [9] = '{{3'h0, 12'h900, 8'h01}, {3'h1, 12'h900, 8'h02},
    {3'h2, 12'h900, 8'h04}, {3'h3, 12'h900, 8'h08}, {3'h4, 12'h900, 8'h10},
    {3'h0, 12'h050, 8'h01}, {3'h1, 12'h400, 8'h00}, {3'h2, 12'h7FC, 8'h04},
    {3'h2, 12'h7F8, 8'h00}};
  oram_top uut (.clk_sys, .resetn, .res_valid, .res_chan, .res_data, .res_ready_n(1'b1),
    .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .gpio_in, .gpio_out,
    .gpio_oe, .conv_clear, .temp_conv_en, .auto_mode, .ref_buf_en, .ext_trigger);
  oram_host host (.clk_sys, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .gpio_oe, .gpio_in);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string w, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, v});
  endtask
  task automatic res(input logic [2:0] c, input logic [11:0] v);
    @(posedge clk_sys);
    res_valid <= 1'b1;
    res_chan <= c;
    res_data <= v;
    @(posedge clk_sys);
    res_valid <= 1'b0;
    res_data <= ~v;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    rdc(8'h7A, 8'hFF);
    rdc(8'h11, 8'h07);
    rdc(8'h16, 8'h00);
    chk("pin drive", 12'h000, {4'h0, gpio_oe});
    host.setup();
    chk("ref buffer", 12'h001, {11'h0, ref_buf_en});
    $display("test reset done");
    host.wr(8'h11, 8'h01);
    for (int k = 0; k < 5; k++) begin
      host.wr(8'h80 + 8'(4 * k), 8'h00);
      host.wr(8'h81 + 8'(4 * k), 8'h08);
      host.wr(8'h82 + 8'(4 * k), 8'h00);
      host.wr(8'h83 + 8'(4 * k), 8'h01);
    end
    for (int i = 0; i < 9; i++) begin
      res(rows[i][22:20], rows[i][19:8]);
      rdc(8'h70, rows[i][7:0]);
    end
    $display("test rows done");
    host.wr(8'h11, 8'h02);
    res(3'h1, 12'h900);
    rdc(8'h70, 8'h00);
    res(3'h1, 12'h900);
    rdc(8'h70, 8'h02);
    host.wr(8'h11, 8'h01);
    res(3'h3, 12'h900);
    host.rd(8'h72, d);
    chk("global flag", 12'h001, {11'h0, d[0]});
    chk("fault pin", 12'h001, {11'h0, gpio_oe[1]});
    host.wr(8'h1C, 8'hFF);
    host.wr(8'h1D, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk("masked pin", 12'h000, {11'h0, gpio_oe[1]});
    rdc(8'h70, 8'h08);
    $display("test mask done");
    host.wr(8'h1D, 8'h80);
    rdc(8'h70, 8'h1B);
    res(3'h3, 12'h400);
    rdc(8'h70, 8'h13);
    rdc(8'h70, 8'h13);
    $display("test live done");
    host.wr(8'h1D, 8'h00);
    host.wr(8'h18, 8'h05);
    host.wr(8'h19, 8'h08);
    host.wr(8'h1B, 8'h01);
    host.ext_high <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("clear", 12'h805, conv_clear);
    rdc(8'h71, 8'h08);
    host.ext_high <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("reload", 12'h000, conv_clear);
    rdc(8'h71, 8'h00);
    $display("test fault input done");
    host.wr(8'h94, 8'h90);
    host.wr(8'h95, 8'h01);
    res(3'h5, 12'h280);
    rdc(8'h71, 8'h00);
    chk("temp enable", 12'h000, {11'h0, temp_conv_en});
    host.wr(8'h15, 8'h01);
    res(3'h5, 12'h280);
    rdc(8'h71, 8'h05);
    rdc(8'h78, 8'h80);
    rdc(8'h79, 8'h02);
    $display("test temperature done");
    rdc(8'h70, 8'h13);
    host.wr(8'hA4, 8'h7F);
    res(3'h4, 12'h790);
    host.wr(8'h1A, 8'h10);
    repeat (2) @(posedge clk_sys);
    chk("alarm clear", 12'h805, conv_clear);
    rdc(8'h70, 8'h10);
    repeat (2) @(posedge clk_sys);
    chk("alarm reload", 12'h000, conv_clear);
    res(3'h4, 12'h781);
    rdc(8'h70, 8'h00);
    $display("test hysteresis done");
    host.wr(8'h10, 8'h03);
    host.wr(8'h12, 8'h07);
    host.trig_high <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("trigger", 12'h001, {11'h0, ext_trigger});
    chk("auto mode", 12'h001, {11'h0, auto_mode});
    chk("pin out", 12'h000, {4'h0, gpio_out});
    host.trig_high <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("trigger off", 12'h000, {11'h0, ext_trigger});
    $display("test trigger done");
    host.wr(8'h7A, 8'h7F);
    repeat (2) @(posedge clk_sys);
    rdc(8'h7A, 8'h7F);
    $display("test pins done");
    finish_test();
  end
endmodule
